// [lsfs_pkg.sv]
// Constants, types and enumerations for the LED string fault supervisor.
// Assumes a 125 MHz core clock and a separate boost switching clock.
//
// Notes on behaviour
// - Boost switching waits until the protection FET reports fully on.
// - Soft-start current limit begins at its lowest step of 275mA.
// - Limit climbs to 2.2A in seven more equal 275mA steps.
// - Steps take at least 8ms total; stretched when LED on-time is scarce.
// - Switching pulse ends in any cycle whose switch current exceeds limit.
// - LED faults are reported in the fault and status register.
// - Output mask register shows channels disabled after a failure.
// - Host may pre-mask bad channels; only unmasked channel faults reported.
// - While feedback says unstable, apparent faults disable no channel.
// - Output short with high input current turns off all channels; bus lives.
// - Shutdown cause is held in the fault and status register.
// - Channels above the short threshold are disabled.
// - Three short thresholds selectable; 5.85V after reset.
// - A configuration setting turns short detection off entirely.
// - Channel becomes good when its current reaches target.
// - Good channel falling below target becomes open circuit.
// - Overvoltage or lower over-temperature makes every non-good channel open.
// - Open channel is disabled only after a time-out, also above lower OTP.
// - Zener-bypassed string stays enabled unless overvoltage is reached.
// - Open time-out lasts six dimming cycles.
// - Upper OTP stops boost, turns sources off, sets thermal fault bit.
`default_nettype none

package lsfs_pkg;

   localparam int NUM_CH = 6;

   // Register offsets
   localparam logic [7:0] FAULT_OFS = 8'h02;
   localparam logic [7:0] CFG_OFS   = 8'h08;
   localparam logic [7:0] MASK_OFS  = 8'h09;

   // Configuration fields and reset value (threshold 5.85V, 600kHz)
   localparam int         CFG_THR_LSB  = 0;
   localparam int         CFG_FREQ_BIT = 2;
   localparam logic [1:0] THR_3V60     = 2'h0;
   localparam logic [1:0] THR_4V80     = 2'h1;
   localparam logic [1:0] THR_5V85     = 2'h2;
   localparam logic [1:0] THR_OFF      = 2'h3;
   localparam logic [7:0] CFG_RST      = 8'h02;
   localparam logic [7:0] MASK_RST     = 8'h00;

   // Fault and status bit positions
   localparam int FLT_SHORT   = 0;
   localparam int FLT_OPEN    = 1;
   localparam int FLT_OVP     = 2;
   localparam int FLT_THERMAL = 3;
   localparam int FLT_VSHORT  = 4;
   localparam int STS_SS_DONE = 5;
   localparam int STS_BOOST   = 6;

   // Soft-start timing
   localparam int         LIMIT_STEP_MA  = 275;
   localparam int         LIMIT_FINAL_MA = 2200;
   localparam int         SS_INCREMENTS  = LIMIT_FINAL_MA / LIMIT_STEP_MA - 1;
   localparam logic [2:0] LIMIT_MAX      = 3'(SS_INCREMENTS);
   localparam int         SS_TOTAL_MS    = 8;
   localparam int         CLK_PERIOD_NS  = 8;
   localparam int         SS_STEP_CYC    =
      (SS_TOTAL_MS * 1000000 / CLK_PERIOD_NS + SS_INCREMENTS - 1) / SS_INCREMENTS;

   // Open circuit time-out in dimming cycles
   localparam logic [2:0] OPEN_TIMEOUT_DIM = 3'h6;

   // Boost switching cycle in switching-clock periods
   localparam int SW_PERIOD_CYC = 8;
   localparam int SW_MAX_ON_CYC = 7;

   localparam logic [6:0] SLAVE_ADDR_RST = 7'h2C; // Arbitrary value

   typedef struct packed {
      logic [NUM_CH-1:0] at_target;
      logic [NUM_CH-1:0] above_short;
   } lsfs_chan_s;

   typedef struct packed {
      logic chip_en;
      logic prot_fet_on;
      logic ovp_hit;
      logic otp_low;
      logic otp_high;
      logic vout_short;
      logic fb_stable;
      logic dim_pwm;
   } lsfs_sys_s;

   typedef enum logic [2:0] {
      SUP_OFF, SUP_INRUSH, SUP_SOFT, SUP_RUN, SUP_SHUT
   } lsfs_sup_e;

   typedef enum logic [2:0] {
      BUS_IDLE, BUS_ADDR, BUS_PTR, BUS_WR, BUS_ACK, BUS_RD, BUS_RACK
   } lsfs_bus_e;

endpackage

`default_nettype wire

// [lsfs_supervisor.sv]
// LED string supervisor: start-up sequencing, channel fault classification,
// fault registers on a two-wire serial register port, and boost pulse limiting.
// Assumes analog comparators deliver levels asynchronously; sw_clk is the
// boost switching clock, unrelated to core_clk.
`default_nettype none

module lsfs_supervisor #(
   parameter int         SS_STEP_CYC = lsfs_pkg::SS_STEP_CYC,
   parameter logic [6:0] SLAVE_ADDR  = lsfs_pkg::SLAVE_ADDR_RST
) (
   input  wire logic                      core_clk,
   input  wire logic                      rst_n,
   input  wire logic                      sw_clk,
   input  wire lsfs_pkg::lsfs_sys_s       sys_in,
   input  wire lsfs_pkg::lsfs_chan_s      chan_in,
   input  wire logic                      sw_over_limit,
   input  wire logic                      scl_in,
   input  wire logic                      sda_in,
   output logic                           sda_out,
   output logic                           sda_oe,
   output logic [lsfs_pkg::NUM_CH-1:0]    chan_en,
   output logic                           prot_fet_gate,
   output logic [1:0]                     short_thr_sel,
   output logic                           sw_freq_hi,
   output logic                           gate_drive,
   output logic [2:0]                     limit_code
);

   localparam int N = lsfs_pkg::NUM_CH;

   function automatic logic [2:0] gray2bin(input logic [2:0] g);
      gray2bin = {g[2], g[2] ^ g[1], g[2] ^ g[1] ^ g[0]};
   endfunction

   // ---------------- Input synchronisers (core domain) ----------------
   lsfs_pkg::lsfs_sys_s  sys_m_ff, sys_s_ff;
   lsfs_pkg::lsfs_chan_s chan_m_ff, chan_s_ff;
   logic [1:0]           pin_m_ff, pin_s_ff, pin_d_ff;
   logic                 dim_d_ff;

   always_ff @(posedge core_clk) begin
      sys_m_ff  <= sys_in;
      sys_s_ff  <= sys_m_ff;
      chan_m_ff <= chan_in;
      chan_s_ff <= chan_m_ff;
      pin_m_ff  <= {scl_in, sda_in};
      pin_s_ff  <= pin_m_ff;
      pin_d_ff  <= pin_s_ff;
      dim_d_ff  <= sys_s_ff.dim_pwm;
   end

   wire en_s     = sys_s_ff.chip_en;
   wire dim_rise = sys_s_ff.dim_pwm & ~dim_d_ff;

   // ---------------- Registers ----------------
   logic [7:0] cfg_ff, mask_ff, fault_ff;
   logic [7:0] nxt_cfg, nxt_mask, nxt_fault;
   logic       wr_stb_ff;
   logic [7:0] wr_addr_ff, wr_data_ff;

   // ---------------- Start-up sequencer ----------------
   lsfs_pkg::lsfs_sup_e sup_ff, nxt_sup;
   logic [31:0]         step_cnt_ff, nxt_step_cnt;
   logic                led_on_seen_ff, nxt_led_on_seen;
   logic [2:0]          limit_ff, nxt_limit;
   logic [2:0]          limit_gray_ff;

   wire step_due  = (step_cnt_ff >= 32'(SS_STEP_CYC - 1));
   wire step_go   = step_due & (led_on_seen_ff | sys_s_ff.dim_pwm);
   wire boost_on  = ((sup_ff == lsfs_pkg::SUP_SOFT) | (sup_ff == lsfs_pkg::SUP_RUN))
                    & ~sys_s_ff.otp_high;
   wire chans_live = (sup_ff == lsfs_pkg::SUP_SOFT) | (sup_ff == lsfs_pkg::SUP_RUN);

   always_comb begin
      nxt_sup         = sup_ff;
      nxt_step_cnt    = step_cnt_ff;
      nxt_led_on_seen = led_on_seen_ff | sys_s_ff.dim_pwm;
      nxt_limit       = limit_ff;
      unique case (sup_ff)
         lsfs_pkg::SUP_OFF: begin
            if (en_s) begin
               nxt_sup = lsfs_pkg::SUP_INRUSH;
            end
         end
         lsfs_pkg::SUP_INRUSH: begin
            nxt_limit = 3'h0;
            if (sys_s_ff.prot_fet_on) begin
               nxt_sup         = lsfs_pkg::SUP_SOFT;
               nxt_step_cnt    = 32'h0;
               nxt_led_on_seen = 1'b0;
            end
         end
         lsfs_pkg::SUP_SOFT: begin
            nxt_step_cnt = step_cnt_ff + 32'h1;
            if (step_go) begin
               nxt_step_cnt    = 32'h0;
               nxt_led_on_seen = 1'b0;
               if (limit_ff == lsfs_pkg::LIMIT_MAX) begin
                  nxt_sup = lsfs_pkg::SUP_RUN;
               end else begin
                  nxt_limit = limit_ff + 3'h1;
               end
            end
         end
         lsfs_pkg::SUP_RUN: begin
            nxt_sup = lsfs_pkg::SUP_RUN;
         end
         lsfs_pkg::SUP_SHUT: begin
            nxt_sup = lsfs_pkg::SUP_SHUT;
         end
         default: begin
            nxt_sup = lsfs_pkg::SUP_OFF;
         end
      endcase
      if (sys_s_ff.vout_short && sup_ff != lsfs_pkg::SUP_OFF) begin
         nxt_sup = lsfs_pkg::SUP_SHUT;
      end
      if (!en_s) begin
         nxt_sup   = lsfs_pkg::SUP_OFF;
         nxt_limit = 3'h0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         sup_ff         <= lsfs_pkg::SUP_OFF;
         step_cnt_ff    <= 32'h0;
         led_on_seen_ff <= 1'b0;
         limit_ff       <= 3'h0;
         limit_gray_ff  <= 3'h0;
      end else begin
         sup_ff         <= nxt_sup;
         step_cnt_ff    <= nxt_step_cnt;
         led_on_seen_ff <= nxt_led_on_seen;
         limit_ff       <= nxt_limit;
         limit_gray_ff  <= nxt_limit ^ (nxt_limit >> 1);
      end
   end

   // ---------------- Channel classification ----------------
   wire [1:0]   thr_sel   = cfg_ff[lsfs_pkg::CFG_THR_LSB +: 2];
   wire         short_on  = (thr_sel != lsfs_pkg::THR_OFF);
   wire         stable    = sys_s_ff.fb_stable;
   wire [N-1:0] ch_active = {N{chans_live}} & ~mask_ff[N-1:0];
   logic [N-1:0] good_ff, open_ff, nxt_good, nxt_open;
   logic [N-1:0] open_trip, short_trip;
   logic [N-1:0] chan_en_ff;
   logic [2:0]   open_cnt_ff [N];

   for (genvar i = 0; i < N; i++) begin : g_ch
      wire at_t     = chan_s_ff.at_target[i];
      wire fall_off = good_ff[i] & ~at_t;
      wire force_op = (sys_s_ff.ovp_hit | sys_s_ff.otp_low) & ~good_ff[i];
      assign nxt_good[i]   = ch_active[i] & at_t;
      assign nxt_open[i]   = ch_active[i] & ~at_t & (open_ff[i] | fall_off | force_op);
      // Time-out counts dimming cycles only while feedback is stable
      assign open_trip[i]  = open_ff[i] & stable & dim_rise
                             & (open_cnt_ff[i] == lsfs_pkg::OPEN_TIMEOUT_DIM - 3'h1);
      assign short_trip[i] = ch_active[i] & short_on & stable
                             & chan_s_ff.above_short[i];

      always_ff @(posedge core_clk) begin
         if (!rst_n || !open_ff[i] || !stable) begin
            open_cnt_ff[i] <= 3'h0;
         end else if (dim_rise) begin
            open_cnt_ff[i] <= open_cnt_ff[i] + 3'h1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         good_ff    <= '0;
         open_ff    <= '0;
         chan_en_ff <= '0;
      end else begin
         good_ff    <= nxt_good;
         open_ff    <= nxt_open;
         chan_en_ff <= ch_active & ~open_trip & ~short_trip
                       & {N{~sys_s_ff.otp_high}};
      end
   end

   // ---------------- Register file ----------------
   wire wr_cfg  = wr_stb_ff & (wr_addr_ff == lsfs_pkg::CFG_OFS);
   wire wr_mask = wr_stb_ff & (wr_addr_ff == lsfs_pkg::MASK_OFS);

   always_comb begin
      nxt_cfg  = wr_cfg ? wr_data_ff : cfg_ff;
      // Hardware disables win over a simultaneous host write
      nxt_mask = (wr_mask ? wr_data_ff : mask_ff)
                 | {2'b00, open_trip | short_trip};
      nxt_fault = fault_ff;
      nxt_fault[lsfs_pkg::FLT_SHORT]   = fault_ff[lsfs_pkg::FLT_SHORT] | (|short_trip);
      nxt_fault[lsfs_pkg::FLT_OPEN]    = fault_ff[lsfs_pkg::FLT_OPEN] | (|open_trip);
      nxt_fault[lsfs_pkg::FLT_OVP]     = fault_ff[lsfs_pkg::FLT_OVP]
                                         | (chans_live & sys_s_ff.ovp_hit);
      nxt_fault[lsfs_pkg::FLT_THERMAL] = fault_ff[lsfs_pkg::FLT_THERMAL]
                                         | (en_s & sys_s_ff.otp_high);
      nxt_fault[lsfs_pkg::FLT_VSHORT]  = fault_ff[lsfs_pkg::FLT_VSHORT]
                                         | (nxt_sup == lsfs_pkg::SUP_SHUT);
      nxt_fault[lsfs_pkg::STS_SS_DONE] = (sup_ff == lsfs_pkg::SUP_RUN);
      nxt_fault[lsfs_pkg::STS_BOOST]   = boost_on;
      nxt_fault[7]                     = 1'b0;
      if (!en_s) begin
         nxt_fault = 8'h00;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cfg_ff   <= lsfs_pkg::CFG_RST;
         mask_ff  <= lsfs_pkg::MASK_RST;
         fault_ff <= 8'h00;
      end else begin
         cfg_ff   <= nxt_cfg;
         mask_ff  <= nxt_mask;
         fault_ff <= nxt_fault;
      end
   end

   // ---------------- Serial register port ----------------
   wire scl_s    = pin_s_ff[1];
   wire sda_s    = pin_s_ff[0];
   wire scl_rise = scl_s & ~pin_d_ff[1];
   wire scl_fall = ~scl_s & pin_d_ff[1];
   wire bus_start = scl_s & pin_d_ff[1] & pin_d_ff[0] & ~sda_s;
   wire bus_stop  = scl_s & pin_d_ff[1] & ~pin_d_ff[0] & sda_s;

   lsfs_pkg::lsfs_bus_e bus_ff, after_ff;
   logic [3:0]          bit_cnt_ff;
   logic [7:0]          shift_ff, ptr_ff;
   logic                sda_oe_ff, nack_ff;

   wire [7:0] rd_data = (ptr_ff == lsfs_pkg::FAULT_OFS) ? fault_ff :
                        (ptr_ff == lsfs_pkg::CFG_OFS)   ? cfg_ff   :
                        (ptr_ff == lsfs_pkg::MASK_OFS)  ? mask_ff  : 8'h00;
   wire       byte_done = scl_fall & (bit_cnt_ff == 4'h8);
   wire       addr_hit  = (shift_ff[7:1] == SLAVE_ADDR);

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         bus_ff     <= lsfs_pkg::BUS_IDLE;
         after_ff   <= lsfs_pkg::BUS_IDLE;
         bit_cnt_ff <= 4'h0;
         shift_ff   <= 8'h00;
         ptr_ff     <= 8'h00;
         sda_oe_ff  <= 1'b0;
         nack_ff    <= 1'b0;
         wr_stb_ff  <= 1'b0;
         wr_addr_ff <= 8'h00;
         wr_data_ff <= 8'h00;
      end else begin
         wr_stb_ff <= 1'b0;
         if (bus_start) begin
            bus_ff     <= lsfs_pkg::BUS_ADDR;
            bit_cnt_ff <= 4'h0;
            sda_oe_ff  <= 1'b0;
         end else if (bus_stop) begin
            bus_ff    <= lsfs_pkg::BUS_IDLE;
            sda_oe_ff <= 1'b0;
         end else begin
            unique case (bus_ff)
               lsfs_pkg::BUS_IDLE: begin
                  sda_oe_ff <= 1'b0;
               end
               lsfs_pkg::BUS_ADDR, lsfs_pkg::BUS_PTR, lsfs_pkg::BUS_WR: begin
                  if (scl_rise) begin
                     shift_ff   <= {shift_ff[6:0], sda_s};
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  end else if (byte_done) begin
                     sda_oe_ff <= 1'b1;
                     bus_ff    <= lsfs_pkg::BUS_ACK;
                     if (bus_ff == lsfs_pkg::BUS_ADDR) begin
                        after_ff <= shift_ff[0] ? lsfs_pkg::BUS_RD : lsfs_pkg::BUS_PTR;
                        if (!addr_hit) begin
                           sda_oe_ff <= 1'b0;
                           bus_ff    <= lsfs_pkg::BUS_IDLE;
                        end
                     end else if (bus_ff == lsfs_pkg::BUS_PTR) begin
                        ptr_ff   <= shift_ff;
                        after_ff <= lsfs_pkg::BUS_WR;
                     end else begin
                        wr_stb_ff  <= 1'b1;
                        wr_addr_ff <= ptr_ff;
                        wr_data_ff <= shift_ff;
                        ptr_ff     <= ptr_ff + 8'h01;
                        after_ff   <= lsfs_pkg::BUS_WR;
                     end
                  end
               end
               lsfs_pkg::BUS_ACK, lsfs_pkg::BUS_RACK: begin
                  if (scl_rise) begin
                     nack_ff <= sda_s;
                  end else if (scl_fall) begin
                     bit_cnt_ff <= 4'h0;
                     sda_oe_ff  <= 1'b0;
                     bus_ff     <= after_ff;
                     if (bus_ff == lsfs_pkg::BUS_RACK && nack_ff) begin
                        bus_ff <= lsfs_pkg::BUS_IDLE;
                     end else if (after_ff == lsfs_pkg::BUS_RD) begin
                        shift_ff  <= rd_data;
                        sda_oe_ff <= ~rd_data[7];
                        ptr_ff    <= ptr_ff + 8'h01;
                     end
                  end
               end
               lsfs_pkg::BUS_RD: begin
                  if (scl_rise) begin
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  end else if (byte_done) begin
                     sda_oe_ff <= 1'b0;
                     bus_ff    <= lsfs_pkg::BUS_RACK;
                     after_ff  <= lsfs_pkg::BUS_RD;
                  end else if (scl_fall) begin
                     shift_ff  <= {shift_ff[6:0], 1'b0};
                     sda_oe_ff <= ~shift_ff[6];
                  end
               end
               default: begin
                  bus_ff <= lsfs_pkg::BUS_IDLE;
               end
            endcase
         end
      end
   end

   // ---------------- Other core outputs ----------------
   logic       prot_fet_ff, sda_out_ff, freq_ff;
   logic [1:0] thr_ff;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         prot_fet_ff <= 1'b0;
         sda_out_ff  <= 1'b0;
         thr_ff      <= lsfs_pkg::CFG_RST[lsfs_pkg::CFG_THR_LSB +: 2];
         freq_ff     <= 1'b0;
      end else begin
         prot_fet_ff <= en_s & (nxt_sup != lsfs_pkg::SUP_SHUT);
         sda_out_ff  <= 1'b0;
         thr_ff      <= nxt_cfg[lsfs_pkg::CFG_THR_LSB +: 2];
         freq_ff     <= nxt_cfg[lsfs_pkg::CFG_FREQ_BIT];
      end
   end

   assign sda_out       = sda_out_ff;
   assign sda_oe        = sda_oe_ff;
   assign chan_en       = chan_en_ff;
   assign prot_fet_gate = prot_fet_ff;
   assign short_thr_sel = thr_ff;
   assign sw_freq_hi    = freq_ff;

   // ---------------- Switching domain ----------------
   logic [1:0] sw_rst_pipe_ff;
   logic [1:0] run_pipe_ff, over_pipe_ff;
   logic [2:0] lim_m_ff, lim_s_ff;
   logic       boost_on_ff;
   logic [2:0] sw_cnt_ff;
   logic       gate_ff;
   logic [2:0] limit_code_ff;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         boost_on_ff <= 1'b0;
      end else begin
         boost_on_ff <= boost_on;
      end
   end

   always_ff @(posedge sw_clk) begin
      sw_rst_pipe_ff <= {sw_rst_pipe_ff[0], rst_n};
      run_pipe_ff    <= {run_pipe_ff[0], boost_on_ff};
      over_pipe_ff   <= {over_pipe_ff[0], sw_over_limit};
      lim_m_ff       <= limit_gray_ff;
      lim_s_ff       <= lim_m_ff;
   end

   wire sw_rst_n = sw_rst_pipe_ff[1];
   wire sw_run   = run_pipe_ff[1];
   wire sw_over  = over_pipe_ff[1];

   always_ff @(posedge sw_clk) begin
      if (!sw_rst_n) begin
         sw_cnt_ff     <= 3'h0;
         gate_ff       <= 1'b0;
         limit_code_ff <= 3'h0;
      end else begin
         limit_code_ff <= gray2bin(lim_s_ff);
         sw_cnt_ff     <= (sw_cnt_ff == 3'(lsfs_pkg::SW_PERIOD_CYC - 1)) ? 3'h0
                          : sw_cnt_ff + 3'h1;
         if (!sw_run || sw_over
             || sw_cnt_ff == 3'(lsfs_pkg::SW_MAX_ON_CYC - 1)) begin
            gate_ff <= 1'b0;
         end else if (sw_cnt_ff == 3'(lsfs_pkg::SW_PERIOD_CYC - 1)) begin
            gate_ff <= 1'b1;
         end
      end
   end

   assign gate_drive = gate_ff;
   assign limit_code = limit_code_ff;

endmodule

`default_nettype wire

// [lsfs_supervisor_checker.sv]
// Port-level assertions for the LED string supervisor.
// Assumes synchronous active-low rst_n shared by both clock domains.
`default_nettype none
module lsfs_supervisor_checker (
   input wire logic                   core_clk,
   input wire logic                   rst_n,
   input wire logic                   sw_clk,
   input wire lsfs_pkg::lsfs_sys_s    sys_in,
   input wire logic                   sw_over_limit,
   input wire logic [5:0]             chan_en,
   input wire logic                   prot_fet_gate,
   input wire logic [1:0]             short_thr_sel,
   input wire logic                   gate_drive,
   input wire logic [2:0]             limit_code
);
   chk_thr_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(rst_n) |-> short_thr_sel == 2'h2) else $error("threshold not 5.85V after reset");
   chk_gate_wait_fet: assert property (@(posedge sw_clk) disable iff (!rst_n)
      !sys_in.prot_fet_on [*8] |-> !gate_drive) else $error("switching before FET on");
   chk_limit_idle: assert property (@(posedge sw_clk) disable iff (!rst_n)
      !sys_in.chip_en [*8] |-> limit_code == 3'h0) else $error("limit not at lowest step");
   chk_limit_steps: assert property (@(posedge sw_clk) disable iff (!rst_n)
      $changed(limit_code) |-> limit_code == $past(limit_code) + 3'h1 || limit_code == 3'h0)
      else $error("limit skipped a step");
   chk_over_limit_cut: assert property (@(posedge sw_clk) disable iff (!rst_n)
      sw_over_limit [*4] |-> !gate_drive) else $error("pulse not ended over limit");
   chk_short_shut: assert property (@(posedge core_clk) disable iff (!rst_n)
      sys_in.vout_short [*5] |=> chan_en == 6'h00 && !prot_fet_gate)
      else $error("outputs alive on output short");
   chk_otp_off: assert property (@(posedge core_clk) disable iff (!rst_n)
      sys_in.otp_high [*5] |=> chan_en == 6'h00) else $error("sources on above upper OTP");
   chk_unstable_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      (sys_in.chip_en && !sys_in.otp_high && !sys_in.vout_short && !sys_in.fb_stable) [*4]
      |=> ($past(chan_en) & ~chan_en) == 6'h00) else $error("channel tripped while unstable");
endmodule
bind lsfs_supervisor lsfs_supervisor_checker i_lsfs_supervisor_checker (.core_clk, .rst_n,
   .sw_clk, .sys_in, .sw_over_limit, .chan_en, .prot_fet_gate, .short_thr_sel, .gate_drive,
   .limit_code);
`default_nettype wire

// [lsfs_host_model.sv]
// Host model: master of the two-wire register port.
// Assumes the bench resolves the open-drain data line with a pull-up.
`default_nettype none
module lsfs_host_model #(
   parameter logic [6:0] ADR = lsfs_pkg::SLAVE_ADDR_RST
) (
   input  wire logic core_clk,
   input  wire logic sda_line,
   output var logic  scl,
   output var logic  sda_rel
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      scl = 1'b1;
      sda_rel = 1'b1;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic bitx(input logic b, output logic r);
      sda_rel = b;
      wt(8);
      scl = 1'b1;
      wt(4);
      r = sda_line;
      wt(4);
      scl = 1'b0;
      wt(2);
   endtask
   task automatic start();
      sda_rel = 1'b1;
      wt(4);
      scl = 1'b1;
      wt(8);
      sda_rel = 1'b0;
      wt(8);
      scl = 1'b0;
      wt(4);
   endtask
   task automatic xfer(input logic [7:0] d, output logic [7:0] r);
      logic a;
      for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
      bitx(1'b1, a);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      start();
      xfer({ADR, 1'b0}, r);
      xfer(a, r);
      xfer(d, r);
      sda_rel = 1'b0;
      wt(4);
      scl = 1'b1;
      wt(8);
      sda_rel = 1'b1;
      wt(8);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      logic [7:0] r;
      start();
      xfer({ADR, 1'b0}, r);
      xfer(a, r);
      start();
      xfer({ADR, 1'b1}, r);
      xfer(8'hFF, q);
      sda_rel = 1'b0;
      wt(4);
      scl = 1'b1;
      wt(8);
      sda_rel = 1'b1;
      wt(8);
   endtask
endmodule
`default_nettype wire

// [lsfs_supervisor_test.sv]
// Self-checking bench of the LED string supervisor.
// Assumes the host model for register traffic; dimming runs free at 40 core cycles.
`default_nettype none
module lsfs_supervisor_test;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int SS = 20;
   logic core_clk = 1'b0;
   logic sw_clk = 1'b0;
   logic rst_n = 1'b0;
   logic sw_over_limit = 1'b0;
   logic scl, sda_rel, sda_out, sda_oe, prot_fet_gate, sw_freq_hi, gate_drive;
   logic [5:0] chan_en;
   logic [1:0] short_thr_sel;
   logic [2:0] limit_code;
   logic [7:0] q;
   lsfs_pkg::lsfs_sys_s sys = '0;
   lsfs_pkg::lsfs_chan_s chn = '0;
   int error_cnt = 0;
   int checks = 0;
   wire logic sda_line = sda_rel & ~(sda_oe & ~sda_out);
   always #4 core_clk = ~core_clk;
   always #62.5 sw_clk = ~sw_clk;
   always begin
      wt(20);
      sys.dim_pwm = ~sys.dim_pwm;
   end
   lsfs_supervisor #(.SS_STEP_CYC(SS)) i_lsfs_supervisor (.core_clk, .rst_n, .sw_clk,
      .sys_in(sys), .chan_in(chn), .sw_over_limit, .scl_in(scl), .sda_in(sda_line), .sda_out,
      .sda_oe, .chan_en, .prot_fet_gate, .short_thr_sel, .sw_freq_hi, .gate_drive, .limit_code);
   lsfs_host_model i_lsfs_host_model (.core_clk, .sda_line, .scl, .sda_rel);
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_lsfs_host_model.wr(a, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      i_lsfs_host_model.rd(a, q);
      check(q & m, e);
   endtask
   task automatic end_of_test();
      $display("mismatches %0d of %0d checks", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic sc_regs();
      rdc(8'h08, 8'hFF, 8'h02);
      rdc(8'h09, 8'hFF, 8'h00);
      wr(8'h02, 8'hFF);
      rdc(8'h02, 8'hFF, 8'h00);
      wr(8'h0F, 8'hFF);
      rdc(8'h0F, 8'hFF, 8'h00);
   endtask
   task automatic sc_thr();
      for (int i = 3; i >= 0; i--) begin
         wr(8'h08, 8'(i) | 8'h04);
         check({5'h0, sw_freq_hi, short_thr_sel}, 8'(i) | 8'h04);
      end
      wr(8'h08, 8'h03);
   endtask
   task automatic sc_start();
      int n;
      wr(8'h09, 8'h01);
      chn.at_target = 6'h2E;
      sys.fb_stable = 1'b1;
      sys.chip_en = 1'b1;
      wt(200);
      check({5'h0, prot_fet_gate, gate_drive, 1'b0}, 8'h04);
      check({5'h0, limit_code}, 8'h00);
      sys.prot_fet_on = 1'b1;
      n = 0;
      while (limit_code !== 3'h7 && n < 3000) begin
         wt(1);
         n++;
      end
      check(8'(n >= 7 * SS && n < 3000), 8'h01);
      rdc(8'h02, 8'hFF, 8'h60);
      check({2'h0, chan_en}, 8'h3E);
      sw_over_limit = 1'b1;
      wt(200);
      check({7'h0, gate_drive}, 8'h00);
      sw_over_limit = 1'b0;
   endtask
   task automatic sc_open();
      chn.at_target[1] = 1'b0;
      wt(120);
      check({2'h0, chan_en}, 8'h3E);
      wt(240);
      check({2'h0, chan_en}, 8'h3C);
      rdc(8'h09, 8'hFF, 8'h03);
      rdc(8'h02, 8'hFF, 8'h62);
   endtask
   task automatic sc_short();
      chn.above_short[2] = 1'b1;
      wt(100);
      check({2'h0, chan_en}, 8'h3C);
      sys.fb_stable = 1'b0;
      wr(8'h08, 8'h02);
      check({2'h0, chan_en}, 8'h3C);
      sys.fb_stable = 1'b1;
      wt(20);
      check({2'h0, chan_en}, 8'h38);
      rdc(8'h02, 8'h03, 8'h03);
      sys.ovp_hit = 1'b1;
      wt(360);
      check({2'h0, chan_en}, 8'h28);
      sys.ovp_hit = 1'b0;
   endtask
   task automatic sc_shut();
      sys.otp_high = 1'b1;
      wt(10);
      check({2'h0, chan_en}, 8'h00);
      sys.otp_high = 1'b0;
      sys.vout_short = 1'b1;
      wt(10);
      check({1'b0, prot_fet_gate, chan_en}, 8'h00);
      sys.vout_short = 1'b0;
      rdc(8'h02, 8'h1F, 8'h1F);
      sys.chip_en = 1'b0;
      sys.prot_fet_on = 1'b0;
      wt(20);
      rdc(8'h02, 8'h1F, 8'h00);
   endtask
   initial begin
      #400000;
      error_cnt++;
      end_of_test();
   end
   initial begin
      wt(50);
      rst_n = 1'b1;
      wt(4);
      sc_regs();
      sc_thr();
      sc_start();
      sc_open();
      sc_short();
      sc_shut();
      end_of_test();
   end
endmodule
`default_nettype wire
